// ---- ingress_policing_defs.svh ----
// Contract
// - Storm bit enables ingress broadcast storm protection.
// - Back pressure only in half duplex with its bit set.
// - Full duplex uses PAUSE flow control, own enable.
// - Bad frames drop unless pass-all, then mirror only.
// - Pass-all keeps flow control frame filtering; a switch bit governs it.
// - Select bit 1 limits per port, 0 per priority.
// - Packet-count mode 1 counts packets, 0 bits.
// - Rate flow control bit asserts flow control when rate exceeded.
// - Limit mode picks counted frames: all, bc/mc/flood, bc/mc, bc only.
// - IFG bit adds twelve gap bytes per frame.
// - Preamble bit adds eight bytes per frame.
// - Preamble bit has no effect in packet-count mode.
// - Priority codes stay pending until priority seven is written.
// - External port transmit flow control needs its enable bit.
`ifndef INGRESS_POLICING_DEFS_SVH
`define INGRESS_POLICING_DEFS_SVH

// Register indices; byte address is four times the index
`define IDX_EXT_CTRL_A 14'h0300
`define IDX_MAC_CTRL_A 14'h0400
`define IDX_MAC_CTRL_B 14'h0401
`define IDX_RATE_CTRL 14'h0403
`define IDX_PRIO0_LIMIT 14'h0410
`define IDX_PRIO7_LIMIT 14'h0417
`define IDX_PORT_LIMIT 14'h0420
`define IDX_STORM_LIMIT 14'h0421
`define IDX_SWITCH_MAC 14'h0430
`define IDX_STATUS 14'h0440

// Writable masks and reset values
`define MASK_EXT_CTRL_A 8'h7F
`define RST_EXT_CTRL_A 8'h50
`define MASK_MAC_CTRL_A 8'h0B
`define MASK_MAC_CTRL_B 8'hBF
`define MASK_RATE_CTRL 8'h7F
`define MASK_LIMIT 8'h7F
`define MASK_SWITCH_MAC 8'h01
`define RST_STORM_LIMIT 8'h40

// Field positions
`define BIT_EXT_DUPLEX 6
`define BIT_EXT_TX_FC 5
`define BIT_STORM_EN 1
`define BIT_BP_EN 3
`define BIT_PASS_ALL 0
`define BIT_PORT_BASED 6
`define BIT_PKT_MODE 5
`define BIT_RATE_FC 4
`define LSB_LIMIT_MODE 2
`define BIT_COUNT_IFG 1
`define BIT_COUNT_PRE 0
`define BIT_FC_FILTER_OFF 0

// Byte counts and rate scaling
`define IFG_BYTES 16'h000C
`define PREAMBLE_BYTES 16'h0008
`define BYTES_PER_CODE 24'h00007D
`define PKTS_PER_CODE 24'h000002

// Measurement interval timing
`define CLK_PERIOD_NS 10
`define INTERVAL_NS 1000000
`define INTERVAL_CYCLES (`INTERVAL_NS / `CLK_PERIOD_NS)

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- ingress_policing_pkg.sv ----
package ingress_policing_pkg;
    typedef logic [6:0] limit_code_t;
    typedef logic [15:0] rate_amount_t;
    typedef logic [23:0] rate_count_t;
    typedef enum logic [1:0] {
        LIMIT_ALL,
        LIMIT_BC_MC_FLOOD,
        LIMIT_BC_MC,
        LIMIT_BC
    } limit_mode_t;
endpackage : ingress_policing_pkg

// ---- rate_meter_if.sv ----
`timescale 1ns/100ps
interface rate_meter_if;
    ingress_policing_pkg::limit_code_t code;
    logic pkt_mode;
    logic hit;
    ingress_policing_pkg::rate_amount_t amount;
    logic tick;
    logic over_now;
    logic over_reg;
    modport meter (input code, input pkt_mode, input hit, input amount, input tick,
        output over_now, output over_reg);
    modport ctrl (output code, output pkt_mode, output hit, output amount, output tick,
        input over_now, input over_reg);
endinterface : rate_meter_if

// ---- rate_meter.sv ----
`timescale 1ns/100ps
`include "ingress_policing_defs.svh"
module rate_meter (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control side
    rate_meter_if.meter m
);
    ingress_policing_pkg::rate_count_t used_reg;
    ingress_policing_pkg::rate_count_t budget;
    logic [24:0] sum;

    // Code zero means no limit
    always_comb begin
        budget = m.pkt_mode ? ingress_policing_pkg::rate_count_t'(m.code) * `PKTS_PER_CODE
            : ingress_policing_pkg::rate_count_t'(m.code) * `BYTES_PER_CODE;
        sum = {1'b0, used_reg} + {9'h000, m.amount};
        m.over_now = m.hit && (m.code != 7'h00) && (sum > {1'b0, budget});
    end

    // Over-rate frames are not counted, so later small frames may still fit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            used_reg <= 24'h000000;
        end else if (m.tick) begin
            used_reg <= 24'h000000;
        end else if (m.hit && !m.over_now) begin
            used_reg <= sum[23:0];
        end
    end

    // Sticky over flag; a new excess wins over the tick
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            m.over_reg <= 1'b0;
        end else if (m.over_now) begin
            m.over_reg <= 1'b1;
        end else if (m.tick) begin
            m.over_reg <= 1'b0;
        end
    end
endmodule : rate_meter

// ---- port_ingress_mac_policing.sv ----
`timescale 1ns/100ps
`include "ingress_policing_defs.svh"
module port_ingress_mac_policing #(
    parameter int INTERVAL_CYCLES = `INTERVAL_CYCLES
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [15:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [15:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Received frame descriptor, one cycle per frame
    input wire logic frame_valid,
    input wire logic [15:0] frame_len,
    input wire logic [2:0] frame_prio,
    input wire logic frame_bcast,
    input wire logic frame_mcast,
    input wire logic frame_flood,
    input wire logic frame_crc_err,
    input wire logic frame_too_long,
    input wire logic frame_too_short,
    input wire logic frame_is_pause,
    // Frame verdict
    output logic verdict_valid,
    output logic verdict_forward,
    output logic verdict_mirror_only,
    output logic verdict_drop,
    // Flow control toward the link partner
    output logic pause_request,
    output logic back_pressure
);
    localparam int NUM_PRIO = 8;

    // Register state
    logic [7:0] ext_ctrl_a_reg;
    logic [7:0] mac_ctrl_a_reg;
    logic [7:0] mac_ctrl_b_reg;
    logic [7:0] rate_ctrl_reg;
    logic [7:0] port_limit_reg;
    logic [7:0] storm_limit_reg;
    logic [7:0] switch_mac_reg;
    ingress_policing_pkg::limit_code_t pend_code [NUM_PRIO];
    ingress_policing_pkg::limit_code_t live_code [NUM_PRIO];
    logic [7:0] drop_count_reg;

    // AXI state
    logic aw_full_reg, w_full_reg, do_write;
    logic [13:0] aw_idx_reg;
    logic [7:0] w_byte_reg;
    logic w_lane_reg;
    logic aw_take, w_take, ar_take;
    logic aw_full_next, w_full_next, bvalid_next, rvalid_next;
    logic [31:0] rd_data;
    logic rd_ok, wr_ok;
    // Policing state
    logic [16:0] interval_reg;
    logic tick;
    logic [7:0] storm_count_reg;
    logic storm_hit_reg;
    rate_meter_if meter_bus [NUM_PRIO] ();
    logic [NUM_PRIO-1:0] over_now_vec, over_reg_vec;

    // Decode of control fields
    logic full_duplex, tx_fc_en, storm_en, bp_en, pass_all, port_based, pkt_mode, rate_fc_en;
    logic fc_filter_off, counted, bad, storm_drop, rate_over, rate_hit, fc_trigger;
    ingress_policing_pkg::limit_mode_t limit_mode;
    ingress_policing_pkg::rate_amount_t amount;
    logic [2:0] meter_sel;

    assign full_duplex = ext_ctrl_a_reg[`BIT_EXT_DUPLEX];
    assign tx_fc_en = ext_ctrl_a_reg[`BIT_EXT_TX_FC];
    assign storm_en = mac_ctrl_a_reg[`BIT_STORM_EN];
    assign bp_en = mac_ctrl_b_reg[`BIT_BP_EN];
    assign pass_all = mac_ctrl_b_reg[`BIT_PASS_ALL];
    assign port_based = rate_ctrl_reg[`BIT_PORT_BASED];
    assign pkt_mode = rate_ctrl_reg[`BIT_PKT_MODE];
    assign rate_fc_en = rate_ctrl_reg[`BIT_RATE_FC];
    assign limit_mode = ingress_policing_pkg::limit_mode_t'(rate_ctrl_reg[`LSB_LIMIT_MODE +: 2]);
    assign fc_filter_off = switch_mac_reg[`BIT_FC_FILTER_OFF];

    // Address and data in either order; answer after both
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
    assign aw_full_next = (aw_full_reg || aw_take) && !do_write;
    assign w_full_next = (w_full_reg || w_take) && !do_write;
    assign bvalid_next = (s_axi_bvalid && !s_axi_bready) || do_write;
    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign rvalid_next = (s_axi_rvalid && !s_axi_rready) || ar_take;

    // Write handshake registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            aw_idx_reg <= 14'h0000;
            w_byte_reg <= 8'h00;
            w_lane_reg <= 1'b0;
        end else begin
            aw_full_reg <= aw_full_next;
            w_full_reg <= w_full_next;
            s_axi_awready <= !aw_full_next && !bvalid_next;
            s_axi_wready <= !w_full_next && !bvalid_next;
            s_axi_bvalid <= bvalid_next;
            if (aw_take) begin
                aw_idx_reg <= s_axi_awaddr[15:2];
            end
            if (w_take) begin
                w_byte_reg <= s_axi_wdata[7:0];
                w_lane_reg <= s_axi_wstrb[0];
            end
            if (do_write) begin
                s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
            end
        end
    end

    // Mapped registers; others answer with an error
    assign wr_ok = (aw_idx_reg == `IDX_EXT_CTRL_A) || (aw_idx_reg == `IDX_MAC_CTRL_A)
        || (aw_idx_reg == `IDX_MAC_CTRL_B) || (aw_idx_reg == `IDX_RATE_CTRL)
        || (aw_idx_reg >= `IDX_PRIO0_LIMIT && aw_idx_reg <= `IDX_PRIO7_LIMIT)
        || (aw_idx_reg == `IDX_PORT_LIMIT) || (aw_idx_reg == `IDX_STORM_LIMIT)
        || (aw_idx_reg == `IDX_SWITCH_MAC) || (aw_idx_reg == `IDX_STATUS);

    // Control registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_ctrl_a_reg <= `RST_EXT_CTRL_A;
            mac_ctrl_a_reg <= 8'h00;
            mac_ctrl_b_reg <= 8'h00;
            rate_ctrl_reg <= 8'h00;
            port_limit_reg <= 8'h00;
            storm_limit_reg <= `RST_STORM_LIMIT;
            switch_mac_reg <= 8'h00;
        end else if (do_write && w_lane_reg) begin
            unique case (aw_idx_reg)
                `IDX_EXT_CTRL_A: ext_ctrl_a_reg <= w_byte_reg & `MASK_EXT_CTRL_A;
                `IDX_MAC_CTRL_A: mac_ctrl_a_reg <= w_byte_reg & `MASK_MAC_CTRL_A;
                `IDX_MAC_CTRL_B: mac_ctrl_b_reg <= w_byte_reg & `MASK_MAC_CTRL_B;
                `IDX_RATE_CTRL: rate_ctrl_reg <= w_byte_reg & `MASK_RATE_CTRL;
                `IDX_PORT_LIMIT: port_limit_reg <= w_byte_reg & `MASK_LIMIT;
                `IDX_STORM_LIMIT: storm_limit_reg <= w_byte_reg;
                `IDX_SWITCH_MAC: switch_mac_reg <= w_byte_reg & `MASK_SWITCH_MAC;
                default: ;
            endcase
        end
    end

    // Codes wait in a shadow set until priority seven is written
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NUM_PRIO; i++) begin
                pend_code[i] <= 7'h00;
                live_code[i] <= 7'h00;
            end
        end else if (do_write && w_lane_reg) begin
            for (int i = 0; i < NUM_PRIO; i++) begin
                if (aw_idx_reg == `IDX_PRIO0_LIMIT + 14'(i)) begin
                    pend_code[i] <= w_byte_reg[6:0];
                end
            end
            if (aw_idx_reg == `IDX_PRIO7_LIMIT) begin
                for (int i = 0; i < NUM_PRIO - 1; i++) begin
                    live_code[i] <= pend_code[i];
                end
                live_code[NUM_PRIO-1] <= w_byte_reg[6:0];
            end
        end
    end

    // Reads show pending codes, status shows live state
    always_comb begin
        rd_data = 32'h00000000;
        rd_ok = 1'b1;
        if (s_axi_araddr[15:2] >= `IDX_PRIO0_LIMIT && s_axi_araddr[15:2] <= `IDX_PRIO7_LIMIT) begin
            rd_data = {25'h0000000, pend_code[s_axi_araddr[4:2]]};
        end else begin
            unique case (s_axi_araddr[15:2])
                `IDX_EXT_CTRL_A: rd_data = {24'h000000, ext_ctrl_a_reg};
                `IDX_MAC_CTRL_A: rd_data = {24'h000000, mac_ctrl_a_reg};
                `IDX_MAC_CTRL_B: rd_data = {24'h000000, mac_ctrl_b_reg};
                `IDX_RATE_CTRL: rd_data = {24'h000000, rate_ctrl_reg};
                `IDX_PORT_LIMIT: rd_data = {24'h000000, port_limit_reg};
                `IDX_STORM_LIMIT: rd_data = {24'h000000, storm_limit_reg};
                `IDX_SWITCH_MAC: rd_data = {24'h000000, switch_mac_reg};
                `IDX_STATUS: rd_data = {16'h0000, drop_count_reg, over_reg_vec};
                default: rd_ok = 1'b0;
            endcase
        end
    end

    // Read channel: one cycle from address to data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else begin
            s_axi_arready <= !rvalid_next;
            s_axi_rvalid <= rvalid_next;
            if (ar_take) begin
                s_axi_rdata <= rd_data;
                s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
            end
        end
    end

    // Measurement interval; counts restart on each tick
    assign tick = (interval_reg == 17'(INTERVAL_CYCLES - 1));
    always_ff @(posedge aclk) begin
        if (!aresetn || tick) begin
            interval_reg <= 17'h00000;
        end else begin
            interval_reg <= interval_reg + 17'h00001;
        end
    end

    // Frame classification
    always_comb begin
        unique case (limit_mode)
            ingress_policing_pkg::LIMIT_ALL: counted = 1'b1;
            ingress_policing_pkg::LIMIT_BC_MC_FLOOD:
                counted = frame_bcast || frame_mcast || frame_flood;
            ingress_policing_pkg::LIMIT_BC_MC: counted = frame_bcast || frame_mcast;
            ingress_policing_pkg::LIMIT_BC: counted = frame_bcast;
        endcase
        // Preamble ignored in packet mode since only frames are counted
        if (pkt_mode) begin
            amount = 16'h0001;
        end else begin
            amount = frame_len + (rate_ctrl_reg[`BIT_COUNT_IFG] ? `IFG_BYTES : 16'h0000)
                + (rate_ctrl_reg[`BIT_COUNT_PRE] ? `PREAMBLE_BYTES : 16'h0000);
        end
    end

    assign bad = frame_crc_err || frame_too_long || frame_too_short;
    assign meter_sel = port_based ? 3'h0 : frame_prio;
    assign rate_hit = frame_valid && !bad && !frame_is_pause && counted;
    assign rate_over = over_now_vec[meter_sel];
    assign storm_drop = storm_en && frame_bcast && storm_hit_reg;

    // One meter per priority; port mode uses meter zero
    generate
        for (genvar g = 0; g < NUM_PRIO; g++) begin : g_meter
            assign meter_bus[g].code = port_based ? ((g == 0) ? port_limit_reg[6:0] : 7'h00)
                                                  : live_code[g];
            assign meter_bus[g].pkt_mode = pkt_mode;
            assign meter_bus[g].hit = rate_hit && (meter_sel == 3'(g));
            assign meter_bus[g].amount = amount;
            assign meter_bus[g].tick = tick;
            assign over_now_vec[g] = meter_bus[g].over_now;
            assign over_reg_vec[g] = meter_bus[g].over_reg;
            rate_meter u_meter (
                .aclk(aclk),
                .aresetn(aresetn),
                .m(meter_bus[g].meter)
            );
        end
    endgenerate

    // Broadcast frames per interval
    always_ff @(posedge aclk) begin
        if (!aresetn || tick) begin
            storm_count_reg <= 8'h00;
            storm_hit_reg <= 1'b0;
        end else if (frame_valid && frame_bcast && !bad && !storm_hit_reg) begin
            storm_count_reg <= storm_count_reg + 8'h01;
            storm_hit_reg <= (storm_count_reg + 8'h01 >= storm_limit_reg);
        end
    end

    // Verdict one cycle after the descriptor
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            verdict_valid <= 1'b0;
            verdict_forward <= 1'b0;
            verdict_mirror_only <= 1'b0;
            verdict_drop <= 1'b0;
        end else begin
            verdict_valid <= frame_valid;
            verdict_forward <= 1'b0;
            verdict_mirror_only <= 1'b0;
            verdict_drop <= 1'b0;
            if (frame_valid) begin
                if (frame_is_pause && !fc_filter_off) begin
                    verdict_drop <= 1'b1;
                end else if (bad) begin
                    verdict_mirror_only <= pass_all;
                    verdict_drop <= !pass_all;
                end else if (storm_drop || (rate_over && !rate_fc_en)) begin
                    verdict_drop <= 1'b1;
                end else begin
                    verdict_forward <= 1'b1;
                end
            end
        end
    end

    // Dropped frame count, saturating
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drop_count_reg <= 8'h00;
        end else if (verdict_drop && drop_count_reg != 8'hFF) begin
            drop_count_reg <= drop_count_reg + 8'h01;
        end
    end

    // Enabling flow control in the PHY is left to software
    assign fc_trigger = rate_fc_en && (|over_reg_vec);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pause_request <= 1'b0;
            back_pressure <= 1'b0;
        end else begin
            pause_request <= full_duplex && tx_fc_en && fc_trigger;
            back_pressure <= !full_duplex && bp_en && fc_trigger;
        end
    end
endmodule : port_ingress_mac_policing

// ---- policing_monitor.sv ----
`timescale 1ns/100ps
module policing_monitor #(
    parameter int INTERVAL_CYCLES = 100000
) (
    // Clock and reset
    input logic aclk,
    input logic aresetn,
    // Register bus
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic s_axi_bvalid,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    // Frame path
    input logic frame_valid,
    input logic frame_crc_err,
    input logic frame_too_long,
    input logic frame_too_short,
    input logic verdict_valid,
    input logic verdict_forward,
    input logic verdict_mirror_only,
    input logic verdict_drop,
    // Flow control
    input logic pause_request,
    input logic back_pressure
);
    // Single clock domain
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_verdict_next; frame_valid |=> verdict_valid; endproperty
    a_verdict_next: assert property (p_verdict_next) else $error("verdict missing");
    property p_onehot; verdict_valid |-> $onehot({verdict_forward, verdict_mirror_only,
        verdict_drop}); endproperty
    a_onehot: assert property (p_onehot) else $error("verdict not one-hot");
    property p_bad_blocked; frame_valid && (frame_crc_err || frame_too_long ||
        frame_too_short) |=> verdict_valid && !verdict_forward; endproperty
    a_bad_blocked: assert property (p_bad_blocked) else $error("bad frame forwarded");
    property p_mirror_cause; frame_valid && !(frame_crc_err || frame_too_long ||
        frame_too_short) |=> !verdict_mirror_only; endproperty
    a_mirror_cause: assert property (p_mirror_cause) else $error("good frame mirrored");
    property p_duplex_excl; !(pause_request && back_pressure); endproperty
    a_duplex_excl: assert property (p_duplex_excl) else $error("both flow modes");
    property p_write_resp; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid; endproperty
    a_write_resp: assert property (p_write_resp) else $error("write response late");
    property p_w_refused; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_w_refused: assert property (p_w_refused) else $error("write taken while busy");
    property p_read_resp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_read_resp: assert property (p_read_resp) else $error("read data late");
    property p_rdata_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
        $stable(s_axi_rdata); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
endmodule : policing_monitor

bind port_ingress_mac_policing policing_monitor #(.INTERVAL_CYCLES(INTERVAL_CYCLES)) mon (.*);

// ---- link_partner_model.sv ----
`timescale 1ns/100ps
module link_partner_model (
    // Clock
    input wire logic aclk,
    // Frame descriptor toward the block
    output logic frame_valid,
    output logic [15:0] frame_len,
    output logic [2:0] frame_prio,
    output logic frame_bcast,
    output logic frame_mcast,
    output logic frame_flood,
    output logic frame_crc_err,
    output logic frame_too_long,
    output logic frame_too_short,
    output logic frame_is_pause
);
    logic [25:0] fields = 26'h0;
    initial frame_valid = 1'b0;
    // Idle fields show the inverse of the last frame
    assign {frame_len, frame_prio, frame_bcast, frame_mcast, frame_flood, frame_crc_err,
        frame_too_long, frame_too_short, frame_is_pause} = fields;
    // Class 0 unicast, 1 flooded, 2 multicast, 3 broadcast; bad is crc, long, short
    task automatic send(input logic [15:0] len, logic [2:0] prio, int cls, logic [2:0] bad,
        logic pause);
        @(posedge aclk);
        frame_valid <= 1'b1;
        fields <= {len, prio, cls == 3, cls == 2, cls == 1, bad, pause};
        @(posedge aclk);
        frame_valid <= 1'b0;
        fields <= ~fields;
    endtask : send
endmodule : link_partner_model

// ---- port_ingress_mac_policing_test.sv ----
`timescale 1ns/100ps
`include "ingress_policing_defs.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
    $display("CHECK FAILED %0t got %h exp %h", $time, (g), (e)); end end
module port_ingress_mac_policing_test;
    localparam int IV = 200;
    localparam logic [1:0] OK = `RESP_OKAY;
    localparam logic [1:0] SE = `RESP_SLVERR;
    localparam logic [3:0] FWD = 4'hC;
    localparam logic [3:0] MIR = 4'hA;
    localparam logic [3:0] DRP = 4'h9;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic frame_valid, frame_bcast, frame_mcast, frame_flood, frame_is_pause;
    logic frame_crc_err, frame_too_long, frame_too_short;
    logic [15:0] frame_len;
    logic [2:0] frame_prio;
    logic verdict_valid, verdict_forward, verdict_mirror_only, verdict_drop;
    logic pause_request, back_pressure;
    logic [2:0] pr = 3'h0;
    int checks = 0, fail_count = 0, cyc = 0;

    port_ingress_mac_policing #(.INTERVAL_CYCLES(IV)) dut (.*);
    link_partner_model lp (.*);

    initial begin
        forever #5 aclk = ~aclk;
    end
    // Cycles since reset; keeps bursts clear of ticks
    always @(posedge aclk) if (aresetn) cyc <= cyc + 1;

    task automatic report_and_stop();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop

    task automatic wr(input logic [15:0] a, logic [7:0] d, logic [1:0] r);
        logic ad = 1'b0, wd = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            ad = ad || s_axi_awready;
            wd = wd || s_axi_wready;
            s_axi_awvalid <= !ad;
            s_axi_wvalid <= !wd;
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        `CHK(s_axi_bresp, r)
    endtask : wr

    // Late ready makes the slave hold its data
    task automatic rd(input logic [15:0] a, logic [7:0] d, logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        repeat (2) @(posedge aclk);
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        `CHK(s_axi_rresp, r)
        if (r == OK) `CHK(s_axi_rdata, {24'h0, d})
    endtask : rd

    task automatic fr(input int c, logic [2:0] bad, logic pz, logic [3:0] e);
        lp.send(16'h003C, pr, c, bad, pz);
        #1;
        `CHK({verdict_valid, verdict_forward, verdict_mirror_only, verdict_drop}, e)
    endtask : fr

    task automatic align();
        do @(posedge aclk); while (cyc % IV != IV / 2);
    endtask : align

    // Three frames in one interval; one over budget b is not counted
    task automatic burst(input int c, a, b, logic fc);
        int n = 0;
        align();
        for (int k = 0; k < 3; k++) begin
            fr(c, 3'b000, 1'b0, (n + a > b && !fc) ? DRP : FWD);
            if (n + a <= b) n += a;
        end
    endtask : burst

    task automatic fcchk(input logic [1:0] e);
        repeat (2) @(posedge aclk);
        #1;
        `CHK({pause_request, back_pressure}, e)
    endtask : fcchk

    // Hang guard, well past the ~5400 cycles needed
    initial begin
        repeat (30000) @(posedge aclk);
        fail_count++;
        report_and_stop();
    end

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        // Reset values, write mask and an unmapped place
        rd(16'h0C00, 8'h50, OK);
        rd(16'h1084, 8'h40, OK);
        rd(16'h100C, 8'h00, OK);
        rd(16'h2000, 8'h00, SE);
        wr(16'h2000, 8'hFF, SE);
        wr(16'h100C, 8'hFF, OK);
        rd(16'h100C, 8'h7F, OK);
        wr(16'h100C, 8'h00, OK);
        // Bad frames, pass-all off then on; pause stays filtered
        for (int p = 0; p < 2; p++) begin
            wr(16'h1004, {7'h00, p[0]}, OK);
            for (int i = 0; i < 3; i++) fr(0, 3'b001 << i, 1'b0, p ? MIR : DRP);
            fr(0, 3'b000, 1'b1, DRP);
        end
        wr(16'h10C0, 8'h01, OK);
        fr(0, 3'b000, 1'b1, FWD);
        wr(16'h10C0, 8'h00, OK);
        wr(16'h1004, 8'h00, OK);
        // Storm limit two, protection off then on
        wr(16'h1084, 8'h02, OK);
        for (int s = 0; s < 2; s++) begin
            wr(16'h1000, {6'h00, s[0], 1'b0}, OK);
            align();
            for (int k = 0; k < 3; k++) fr(3, 3'h0, 1'h0, (s + k == 3) ? DRP : FWD);
        end
        wr(16'h1000, 8'h00, OK);
        // Each limit mode against each class; code one is two packets
        wr(16'h1080, 8'h01, OK);
        for (int m = 0; m < 4; m++) begin
            wr(16'h100C, {4'h6, m[1:0], 2'h0}, OK);
            for (int c = 0; c < 4; c++) burst(c, 1, (c >= m) ? 2 : 99, 1'b0);
        end
        // Bit mode allows 125 bytes; gap and preamble in all mixes
        for (int i = 0; i < 4; i++) begin
            wr(16'h100C, {6'b010000, i[1:0]}, OK);
            burst(0, 60 + 12 * i[1] + 8 * i[0], 125, 1'b0);
        end
        wr(16'h100C, 8'h61, OK);
        burst(0, 1, 2, 1'b0);
        // Priority codes wait for the priority seven write
        wr(16'h100C, 8'h20, OK);
        wr(16'h1040, 8'h01, OK);
        rd(16'h1040, 8'h01, OK);
        burst(0, 1, 99, 1'b0);
        wr(16'h105C, 8'h00, OK);
        burst(0, 1, 2, 1'b0);
        pr = 3'h1;
        burst(0, 1, 99, 1'b0);
        pr = 3'h0;
        // Rate flow control, full then half duplex, one interval
        wr(16'h100C, 8'h70, OK);
        wr(16'h0C00, 8'h60, OK);
        burst(0, 1, 2, 1'b1);
        fcchk(2'b10);
        wr(16'h1004, 8'h08, OK);
        fcchk(2'b10);
        wr(16'h0C00, 8'h40, OK);
        fcchk(2'b00);
        wr(16'h0C00, 8'h20, OK);
        fcchk(2'b01);
        wr(16'h100C, 8'h60, OK);
        fcchk(2'b00);
        report_and_stop();
    end
endmodule : port_ingress_mac_policing_test
